// *** core/flag_exec_core.sv ***
// executor for bit transfer, status flag and processor control instructions
`include "flag_exec_map.svh"

module flag_exec_core
    import flag_exec_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // instruction from program memory
    input  wire instr_word_type    instr,
    // working register file read port
    output      logic [4:0]        reg_read_index,
    input  wire logic [7:0]        reg_read_data,
    // working register file write port
    output      reg_write_type     reg_write,
    // status and control
    input  wire logic              debug_enable,
    output      logic [7:0]        status_flags,
    output      control_pulse_type control_pulse,
    output      logic              instr_done
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic [15:0] word;
    logic [2:0]  bit_sel;
    logic [2:0]  flag_sel;
    logic [7:0]  flag_mask;
    logic [7:0]  bit_mask;
    logic        is_swap;
    logic        is_flag_set;
    logic        is_flag_clear;
    logic        is_bit_store;
    logic        is_bit_load;
    logic        is_sleep;
    logic        is_watchdog;
    logic        is_break;
    logic        store_bit;
    logic [7:0]  loaded_value;
    logic [7:0]  swapped_value;

    assign word          = instr.word;
    assign bit_sel       = word[`BIT_FIELD_MSB:0];
    assign flag_sel      = word[`FLAG_FIELD_MSB:`FLAG_FIELD_LSB];
    assign flag_mask     = 8'h01 << flag_sel;
    assign bit_mask      = 8'h01 << bit_sel;
    // the read index is combinational so the register file answers in the same cycle
    assign reg_read_index = word[`REG_FIELD_MSB:`REG_FIELD_LSB];

    // bit 3 must be clear on bit store and load; a word nothing claims retires as a no-op
    assign is_swap       = (word & `MASK_SWAP) == `CODE_SWAP;
    assign is_flag_set   = (word & `MASK_FLAG_OP) == `CODE_FLAG_SET;
    assign is_flag_clear = (word & `MASK_FLAG_OP) == `CODE_FLAG_CLEAR;
    assign is_bit_store  = (word & `MASK_BIT_OP) == `CODE_BIT_STORE;
    assign is_bit_load   = (word & `MASK_BIT_OP) == `CODE_BIT_LOAD;
    assign is_sleep      = word == `CODE_SLEEP;
    assign is_watchdog   = word == `CODE_WATCHDOG;
    assign is_break      = word == `CODE_BREAK;

    // the transfer flag comes from the register, so a store just before a load is seen
    assign store_bit     = reg_read_data[bit_sel];
    assign loaded_value  = status_flags[`FLAG_TRANSFER] ? (reg_read_data | bit_mask)
                                                        : (reg_read_data & ~bit_mask);
    assign swapped_value = {reg_read_data[3:0], reg_read_data[7:4]};

    // ----------------------------------------
    // execute
    // ----------------------------------------
    logic [7:0]        next_status_flags;
    reg_write_type     next_reg_write;
    control_pulse_type next_control_pulse;
    logic              next_instr_done;

    // the flags have no other writer, so nothing here arbitrates against other groups
    always_comb begin
        next_status_flags        = status_flags;
        next_reg_write           = reg_write;
        next_reg_write.valid     = 1'b0;
        next_control_pulse       = '0;
        next_instr_done          = 1'b0;
        if (instr.valid) begin
            // every opcode here retires in one clock except break, which has no count
            next_instr_done = !is_break;
            if (is_flag_set) begin
                // set carry, negative, zero, interrupt, sign, overflow, transfer, half carry
                next_status_flags = status_flags | flag_mask;
            end else if (is_flag_clear) begin
                next_status_flags = status_flags & ~flag_mask;
            end else if (is_bit_store) begin
                next_status_flags[`FLAG_TRANSFER] = store_bit;
            end else if (is_bit_load) begin
                next_reg_write = '{valid: 1'b1, index: reg_read_index,
                                   data: loaded_value};
            end else if (is_swap) begin
                next_reg_write = '{valid: 1'b1, index: reg_read_index,
                                   data: swapped_value};
            end else if (is_sleep) begin
                next_control_pulse.sleep = 1'b1;
            end else if (is_watchdog) begin
                next_control_pulse.watchdog = 1'b1;
            end else if (is_break) begin
                // without a debugger attached the opcode just falls through with no effect
                next_control_pulse.debug_break = debug_enable;
            end
        end
    end

    // reset wins over ce: a frozen core still comes out of reset clean
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_flags  <= `STATUS_RESET;
            reg_write     <= '0;
            control_pulse <= '0;
            instr_done    <= 1'b0;
        end else if (ce) begin
            status_flags  <= next_status_flags;
            reg_write     <= next_reg_write;
            control_pulse <= next_control_pulse;
            instr_done    <= next_instr_done;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking main_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    logic accept;
    assign accept = ce && instr.valid;

    bit_store_a: assert property (accept && is_bit_store |=>
        status_flags[`FLAG_TRANSFER] == $past(reg_read_data[bit_sel])
        && (status_flags & 8'hbf) == ($past(status_flags) & 8'hbf) && !reg_write.valid)
        else $error("bit store did not copy into transfer flag alone");

    // a frozen core keeps the write strobe up, so only a live edge must drop it
    bit_load_a: assert property (accept && is_bit_load |=>
        reg_write.valid && reg_write.data[$past(bit_sel)] == $past(status_flags[`FLAG_TRANSFER])
        && ((reg_write.data ^ $past(reg_read_data)) & ~(8'h01 << $past(bit_sel))) == 8'h00
        && reg_write.index == $past(reg_read_index) && $stable(status_flags)
        ##1 (!reg_write.valid || $past(accept) || !$past(ce)))
        else $error("bit load wrote wrong value or touched flags");

    half_set_a: assert property (accept && is_flag_set
        && flag_sel == `FLAG_HALF_CARRY |=> status_flags == ($past(status_flags) | 8'h20))
        else $error("set half carry misbehaved");

    half_clear_a: assert property (accept && is_flag_clear
        && flag_sel == `FLAG_HALF_CARRY |=> status_flags == ($past(status_flags) & 8'hdf))
        else $error("clear half carry misbehaved");

    intr_flag_a: assert property (accept && (is_flag_set || is_flag_clear)
        && flag_sel == `FLAG_INTERRUPT |=> status_flags[7] == $past(is_flag_set)
        && status_flags[6:0] == $past(status_flags[6:0]))
        else $error("interrupt enable flag not driven correctly");

    sign_flag_a: assert property (accept && (is_flag_set || is_flag_clear)
        && flag_sel == `FLAG_SIGN |=> status_flags[4] == $past(is_flag_set)
        && instr_done)
        else $error("sign flag not driven correctly");

    overflow_set_a: assert property (accept && is_flag_set
        && flag_sel == `FLAG_OVERFLOW |=> status_flags == ($past(status_flags) | 8'h08))
        else $error("set overflow misbehaved");

    overflow_clear_a: assert property (accept && is_flag_clear
        && flag_sel == `FLAG_OVERFLOW |=> status_flags == ($past(status_flags) & 8'hf7))
        else $error("clear overflow misbehaved");

    sleep_pulse_a: assert property (accept && is_sleep |=> control_pulse.sleep
        && instr_done && $stable(status_flags))
        else $error("sleep request missing or flags changed");

    watchdog_pulse_a: assert property (accept && is_watchdog |=>
        control_pulse.watchdog && instr_done && $stable(status_flags)
        ##1 (!control_pulse.watchdog || $past(accept) || !$past(ce)))
        else $error("watchdog restart request wrong");

    break_flags_a: assert property (accept && is_break |=> $stable(status_flags)
        && !instr_done && control_pulse.debug_break == $past(debug_enable))
        else $error("break altered flags or retired");

    swap_nibble_a: assert property (accept && is_swap |=> reg_write.valid
        && reg_write.data == {$past(reg_read_data[3:0]), $past(reg_read_data[7:4])}
        && reg_write.index == $past(reg_read_index) && $stable(status_flags))
        else $error("nibble swap wrong");

    // every registered output holds while frozen, pulses included
    freeze_a: assert property (!ce |=> $stable(status_flags) && $stable(reg_write)
        && $stable(control_pulse) && $stable(instr_done))
        else $error("state moved while clock enable low");

    flag_force_a: assert property (accept && (is_flag_set || is_flag_clear) |=>
        status_flags[$past(flag_sel)] == $past(is_flag_set)
        && ((status_flags ^ $past(status_flags)) & ~(8'h01 << $past(flag_sel))) == 8'h00)
        else $error("flag set or clear missed its flag or touched another");

    retire_one_a: assert property (accept && !is_break |=> instr_done)
        else $error("accepted instruction did not retire in one clock");

    // no word, no effect: pulses drop and the write port keeps its last index
    idle_quiet_a: assert property (ce && !instr.valid |=> !instr_done
        && control_pulse == '0 && !reg_write.valid
        && reg_write.index == $past(reg_write.index) && $stable(status_flags))
        else $error("idle cycle produced a result");

    // ----------------------------------------
    // cover points
    // ----------------------------------------
    store_load_c: cover property (accept && is_bit_store ##1 accept && is_bit_load);
    flag_pair_c: cover property (accept && is_flag_set ##1 accept && is_flag_clear);
    swap_seen_c: cover property (accept && is_swap);
    break_seen_c: cover property (accept && is_break && debug_enable);
    freeze_seen_c: cover property (!ce && instr.valid);

endmodule // flag_exec_core

// *** core/flag_exec_map.svh ***
// constants for the bit, flag and control instruction executor
// Summary of operation
// - bit store copies selected source bit into transfer flag, one clock, only that flag.
// - bit load writes transfer flag into selected destination bit, flags kept, one clock.
// - set half carry forces half-carry flag to one, nothing else, one clock.
// - clear half carry forces half-carry flag to zero, nothing else, one clock.
// - interrupt enable sets, disable clears the global interrupt flag, one clock.
// - set sign drives signed-test flag high, clear sign drives it low, one clock.
// - set overflow drives the overflow flag high, others untouched, one clock.
// - clear overflow drives the overflow flag low, others untouched, one clock.
// - sleep takes one clock, keeps flags, hands control to sleep logic.
// - watchdog restart takes one clock, keeps flags, tells watchdog to restart count.
// - break matters only to debug logic, no cycle count, changes no flag.
`ifndef FLAG_EXEC_MAP_SVH
`define FLAG_EXEC_MAP_SVH

// ----------------------------------------
// status flag positions
// ----------------------------------------
`define FLAG_CARRY       3'd0
`define FLAG_ZERO        3'd1
`define FLAG_NEGATIVE    3'd2
`define FLAG_OVERFLOW    3'd3
`define FLAG_SIGN        3'd4
`define FLAG_HALF_CARRY  3'd5
`define FLAG_TRANSFER    3'd6
`define FLAG_INTERRUPT   3'd7
`define STATUS_RESET     8'h00

// ----------------------------------------
// instruction field positions
// ----------------------------------------
`define REG_FIELD_MSB    8
`define REG_FIELD_LSB    4
`define BIT_FIELD_MSB    2
`define FLAG_FIELD_MSB   6
`define FLAG_FIELD_LSB   4

// ----------------------------------------
// opcode match masks and values
// ----------------------------------------
`define MASK_SWAP        16'hfe0f
`define CODE_SWAP        16'h9402
`define MASK_FLAG_OP     16'hff8f
`define CODE_FLAG_SET    16'h9408
`define CODE_FLAG_CLEAR  16'h9488
`define MASK_BIT_OP      16'hfe08
`define CODE_BIT_STORE   16'hfa00
`define CODE_BIT_LOAD    16'hf800
`define CODE_NOP         16'h0000
`define CODE_SLEEP       16'h9588
`define CODE_WATCHDOG    16'h95a8
`define CODE_BREAK       16'h9598

`endif

// *** core/flag_exec_pkg.sv ***
// types shared by the bit, flag and control instruction executor
package flag_exec_pkg;

    // instruction word from program memory
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } instr_word_type;

    // write request towards the working register file
    typedef struct packed {
        logic       valid;
        logic [4:0] index;
        logic [7:0] data;
    } reg_write_type;

    // one-cycle requests to neighbouring control logic
    typedef struct packed {
        logic sleep;
        logic watchdog;
        logic debug_break;
    } control_pulse_type;

endpackage

// *** tb/prog_mem_model.sv ***
// program memory and working register model facing the executor
module prog_mem_model
    import flag_exec_pkg::*;
(
    // clock
    input  wire logic           ref_clk,
    // instruction stream
    output      instr_word_type instr,
    // register read port
    input  wire logic [4:0]     reg_read_index,
    output      logic [7:0]     reg_read_data
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] noise = 8'h00;
    logic       released = 1'b0;

    // ----------------------------------------
    // register contents and instruction issue
    // ----------------------------------------
    initial instr = '0;
    // no instruction in flight: the read data is junk that moves every cycle
    always @(posedge ref_clk) noise <= noise + 8'h5b;
    assign reg_read_data = instr.valid ? (8'h3c ^ {reg_read_index[2:0], reg_read_index}) : noise;

    // after a release the next word waits one idle cycle, so the
    // instruction lines are never assigned twice in one time step
    task automatic issue(input logic [15:0] w, input logic keep);
        if (released) begin
            @(posedge ref_clk);
            #1;
        end
        instr = {1'b1, w};
        @(posedge ref_clk);
        #1;
        released = !keep;
        if (!keep) instr = {1'b0, ~w};
    endtask
endmodule // prog_mem_model

// *** tb/test_bit_flag_mcu_control_exec.sv ***
// self-checking bench for the bit, flag and control instruction executor
module test_bit_flag_mcu_control_exec
    import flag_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic              ref_clk, reset, ce, debug_enable;
    instr_word_type    instr;
    logic [4:0]        reg_read_index;
    logic [7:0]        reg_read_data;
    reg_write_type     reg_write;
    logic [7:0]        status_flags;
    control_pulse_type control_pulse;
    logic              instr_done;
    logic [7:0]        exp_flags;
    int                num_errors;
    int                cmp_count;

    `define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
        $display("FAIL at %0t got %h expected %h", $time, got, exp); end end

    // ----------------------------------------
    // design and partner
    // ----------------------------------------
    flag_exec_core dut (.ref_clk, .reset, .ce, .instr, .reg_read_index, .reg_read_data,
                        .reg_write, .debug_enable, .status_flags, .control_pulse, .instr_done);
    prog_mem_model mem (.ref_clk, .instr, .reg_read_index, .reg_read_data);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // helpers and scenarios
    // ----------------------------------------
    function automatic logic [7:0] reg_value(input logic [4:0] i);
        return 8'h3c ^ {i[2:0], i};
    endfunction

    // every executed word must keep all flags but the expected ones
    task automatic run(input logic [15:0] w, input logic keep, input logic done);
        mem.issue(w, keep);
        `CHECK(instr_done, done)
        `CHECK(status_flags, exp_flags)
    endtask

    task automatic test_flags();
        int s;
        for (int k = 0; k < 8; k++) begin
            exp_flags[k] = 1'b1;
            run(16'h9408 | (16'(k) << 4), 1'(k < 7), 1'b1);
        end
        for (int k = 0; k < 8; k++) begin
            s = (k * 2) % 8 + k / 4;
            exp_flags[s] = 1'b0;
            run(16'h9488 | (16'(s) << 4), 1'(k < 7), 1'b1);
        end
        $display("test flags done");
    endtask

    task automatic test_bits();
        logic [7:0] d;
        for (int b = 0; b < 8; b++) begin
            d = reg_value(5'(b + 3));
            exp_flags[6] = d[b];
            run(16'hfa00 | (16'(b + 3) << 4) | 16'(b), 1'b1, 1'b1);
            d = reg_value(5'(b + 20));
            d[b] = exp_flags[6];
            run(16'hf800 | (16'(b + 20) << 4) | 16'(b), 1'b0, 1'b1);
            `CHECK(reg_write, {1'b1, 5'(b + 20), d})
        end
        $display("test bits done");
    endtask

    task automatic test_swap();
        logic [7:0] d;
        d = reg_value(5'd31);
        run(16'h95f2, 1'b0, 1'b1);
        `CHECK(reg_write, {1'b1, 5'd31, d[3:0], d[7:4]})
        $display("test swap done");
    endtask

    // a reset in mid-run wipes the flags and every registered output
    task automatic test_reset();
        exp_flags[0] = 1'b1;
        run(16'h9408, 1'b1, 1'b1);
        run(16'h9402, 1'b0, 1'b1);
        reset = 1'b1;
        @(posedge ref_clk);
        #1;
        exp_flags = 8'h00;
        `CHECK(status_flags, exp_flags)
        `CHECK({reg_write, control_pulse, instr_done}, 18'h00000)
        reset = 1'b0;
        @(posedge ref_clk);
        #1;
        `CHECK(status_flags, exp_flags)
        $display("test reset done");
    endtask

    task automatic ctl(input logic [15:0] w, input logic de, input logic [2:0] p, input logic dn);
        debug_enable = de;
        run(w, 1'b0, dn);
        `CHECK(control_pulse, p)
        @(posedge ref_clk);
        #1;
        `CHECK(control_pulse, 3'b000)
        `CHECK(reg_write.valid, 1'b0)
    endtask

    task automatic test_ctrl();
        ctl(16'h9588, 1'b0, 3'b100, 1'b1);
        ctl(16'h95a8, 1'b0, 3'b010, 1'b1);
        ctl(16'h0000, 1'b1, 3'b000, 1'b1);
        ctl(16'h9598, 1'b0, 3'b000, 1'b0);
        ctl(16'h9598, 1'b1, 3'b001, 1'b0);
        // frozen core: a set carry must leave no trace
        ce = 1'b0;
        run(16'h9408, 1'b0, 1'b0);
        ce = 1'b1;
        $display("test control done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        debug_enable = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        exp_flags = 8'h00;
        repeat (6) @(posedge ref_clk);
        #1;
        `CHECK(status_flags, 8'h00)
        reset = 1'b0;
        @(posedge ref_clk);
        #1;
        test_flags();
        test_bits();
        test_swap();
        test_reset();
        test_ctrl();
        summarize();
    end

    // the scenarios need well under a thousand cycles
    initial begin
        #50000;
        num_errors++;
        summarize();
    end
endmodule // test_bit_flag_mcu_control_exec
